//--- dv/cld_decoder_tb.sv
`timescale 1ns/100ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin num_errors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module cld_decoder_tb;
    import cld_pkg::*;
    localparam int LC = 100;
    localparam int SC = 8;
    logic       clk, rst_n, sel, wr, rd, dval, busy, wide, pon, con, fon, stp, pan, gt;
    logic       blank, here;
    logic [7:0] din, dout, schar, a, b;
    logic [6:0] ptr, poff, saddr, p;
    cld_fmt_t   fmt;
    int         num_errors, check_count, seed, n;
    logic [7:0] fs[4] = '{8'h20, 8'h24, 8'h38, 8'h3c};

    cld_decoder #(.LONG_CYC(LC), .SHORT_CYC(SC), .BLINK_CYC(16)) uut (
        .clk(clk), .rst_n(rst_n), .cmd_data_sel(sel), .wr_stb(wr), .rd_stb(rd),
        .data_in(din), .data_out(dout), .data_out_valid(dval), .in_progress(busy),
        .ram_pointer(ptr), .bus_width_sel(wide), .disp_format(fmt), .panel_on(pon),
        .cursor_on(con), .flash_on(fon), .step_up(stp), .auto_pan(pan),
        .pan_offset(poff), .glyph_target(gt), .scan_addr(saddr), .scan_char(schar),
        .scan_blank(blank), .scan_cursor_here(here));
    cld_host_model hm (.clk(clk), .in_progress(busy), .bus_width_sel(wide),
        .wr_stb(wr), .rd_stb(rd), .cmd_data_sel(sel), .data_in(din));

    function automatic cld_fmt_t fmt_of(input logic [7:0] c);
        return c[3] ? CLD_FMT_2L_5X8 : (c[2] ? CLD_FMT_1L_5X11 : CLD_FMT_1L_5X8);
    endfunction
    function automatic logic [6:0] step(input logic [6:0] q, input logic up);
        return up ? q + 7'h01 : q - 7'h01;
    endfunction

    task automatic conclude();
        $display("checks=%0d errors=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic busy_len(input int e);
        n = 0;
        while (busy === 1'b1 && n < 2000) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK(n >= e - 2 && n <= e, 1'b1)
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // run needs about a thousand cycles
    initial begin
        #(8 * 20000);
        num_errors++;
        conclude();
    end

    initial begin
        rst_n = 1'b0;
        saddr = 7'h00;
        seed = 32'hc265396f;
        num_errors = 0;
        check_count = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        `CHK({busy, ptr, stp, wide}, {1'b0, 7'h00, 1'b1, 1'b1})
        hm.xfer(0, 0, 8'h0c, 0);
        hm.xfer(0, 0, 8'h04, 0);
        hm.xfer(0, 0, 8'h01, 0);
        `CHK(busy, 1'b1)
        busy_len(LC);
        @(posedge clk);
        saddr <= 7'($unsigned($random(seed)) % 80);
        #1;
        `CHK({schar, ptr, stp}, {8'h20, 7'h00, 1'b1})
        a = 8'($unsigned($random(seed)) % 64) | 8'h01;
        b = 8'($random(seed));
        hm.xfer(0, 0, 8'h80 | a, 0);
        `CHK(ptr, a[6:0])
        hm.xfer(1, 0, b, 0);
        `CHK(busy, 1'b1)
        busy_len(SC);
        `CHK(ptr, step(a[6:0], 1'b1))
        hm.xfer(1, 1, 8'h00, 0);
        `CHK(dval, 1'b0)
        hm.xfer(0, 0, 8'h80 | a, 0);
        hm.xfer(1, 1, 8'h00, 0);
        `CHK({dval, dout, ptr}, {1'b1, b, step(a[6:0], 1'b1)})
        hm.xfer(0, 0, 8'h04, 0);
        hm.xfer(0, 0, 8'h80 | a, 0);
        hm.xfer(1, 0, b, 0);
        `CHK(ptr, step(a[6:0], 1'b0))
        hm.xfer(0, 0, 8'h07, 0);
        hm.xfer(1, 0, b, 0);
        `CHK(poff != 7'h00, 1'b1)
        p = poff;
        hm.xfer(0, 0, 8'h80, 0);
        hm.xfer(1, 1, 8'h00, 0);
        `CHK(poff, p)
        hm.xfer(0, 0, 8'h06, 0);
        hm.xfer(0, 0, 8'h40 | a, 0);
        `CHK({gt, ptr}, {1'b1, 1'b0, a[5:0]})
        hm.xfer(1, 0, b, 0);
        `CHK(ptr, {1'b0, a[5:0] + 6'h01})
        hm.xfer(0, 0, 8'h0f, 0);
        `CHK({pon, con, fon, blank}, 4'b1110)
        hm.xfer(0, 0, 8'h0c, 0);
        `CHK({con, stp}, 2'b01)
        foreach (fs[i]) begin
            hm.xfer(0, 0, fs[i], 0);
            `CHK(fmt, fmt_of(fs[i]))
        end
        hm.xfer(0, 0, 8'ha7, 0);
        hm.xfer(0, 0, 8'h14, 0);
        `CHK(ptr, 7'h40)
        p = poff;
        hm.xfer(0, 0, 8'h1c, 0);
        `CHK({ptr, poff != p}, {7'h40, 1'b1})
        hm.xfer(0, 0, 8'h02, 0);
        busy_len(LC);
        `CHK({ptr, poff}, {7'h00, 7'h00})
        hm.xfer(0, 0, 8'h0f, 0);
        @(posedge clk);
        saddr <= 7'h00;
        repeat (16) @(posedge clk);
        #1;
        `CHK({here, schar}, {1'b1, 8'hff})
        a = a & 8'h1f;
        hm.xfer(0, 0, 8'h80 | a, 0);
        hm.xfer(0, 1, 8'h00, 1);
        `CHK(dout, {1'b1, a[6:0]})
        hm.xfer(0, 0, 8'h85, 1);
        hm.xfer(0, 1, 8'h00, 0);
        `CHK(dout, {1'b0, a[6:0]})
        hm.xfer(0, 0, 8'h2c, 0);
        `CHK(wide, 1'b0)
        hm.xfer(0, 0, 8'h80 | a, 0);
        `CHK(ptr, a[6:0])
        hm.xfer(0, 0, 8'h3c, 0);
        `CHK(wide, 1'b1)
        repeat (6) begin
            a = 8'h08 + 8'($unsigned($random(seed)) % 16);
            b = 8'($random(seed));
            hm.xfer(0, 0, {6'h01, b[0], b[1]}, 0);
            hm.xfer(0, 0, 8'h80 | a, 0);
            hm.xfer(1, 0, b, 0);
            `CHK(ptr, step(a[6:0], b[0]))
        end
        conclude();
    end
endmodule

//--- dv/cld_host_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// host processor driving the parallel transfer strobes
// ----------------------------------------------------------------
module cld_host_model (
    // clock and device status
    input  wire logic       clk,
    input  wire logic       in_progress,
    input  wire logic       bus_width_sel,
    // transfer lines
    output logic            wr_stb,
    output logic            rd_stb,
    output logic            cmd_data_sel,
    output logic [7:0]      data_in
);
    initial begin
        wr_stb       = 1'b0;
        rd_stb       = 1'b0;
        cmd_data_sel = 1'b0;
        data_in      = 8'h00;
    end

    task automatic strobe(input logic sel, input logic rd, input logic [7:0] b);
        @(posedge clk);
        cmd_data_sel <= sel;
        data_in      <= b;
        wr_stb       <= !rd;
        rd_stb       <= rd;
        @(posedge clk);
        wr_stb       <= 1'b0;
        rd_stb       <= 1'b0;
        // released bus must not show the old byte
        data_in      <= ~b;
        #1;
    endtask

    // nw skips the busy poll: status reads, or a deliberate early write
    task automatic xfer(input logic sel, input logic rd, input logic [7:0] b, input logic nw);
        int n;
        n = 0;
        while (!nw && in_progress !== 1'b0 && n < 2000) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (!nw) @(posedge clk);
        // parallel host only; a serial host would keep the width bit at one
        if (bus_width_sel) strobe(sel, rd, b);
        else begin
            strobe(sel, rd, {b[7:4], 4'h0});
            strobe(sel, rd, {b[3:0], 4'h0});
        end
    endtask
endmodule

//--- logic/cld_decoder.sv
`timescale 1ns/100ps
`include "cld_defines.svh"
// Behaviour
// [RULE_01] clear fills spaces, pointer zero, step up
// [RULE_02] clear and home busy 0.76 ms
// [RULE_03] others busy 18.5 us, status read free
// [RULE_04] home zeroes pointer and shift, keeps memory
// [RULE_05] step bit chooses pointer increment or decrement
// [RULE_06] auto-pan shifts display on character writes
// [RULE_07] glyph accesses step like character accesses
// [RULE_08] display control stores panel, cursor, flash
// [RULE_09] cursor off keeps step direction
// [RULE_10] flash alternates all-ones and character, 185 ms
// [RULE_11] shift moves cursor or whole display
// [RULE_12] display shift keeps pointer, all lines
// [RULE_13] two-line cursor wraps 27h to 40h
// [RULE_14] function set bit 4 picks bus width
// [RULE_15] host keeps width one on serial links
// [RULE_16] row and height bits select format
// [RULE_17] glyph address loads six bits, glyph target
// [RULE_18] character address loads seven bits, char target
// [RULE_19] status read gives busy and pointer
// [RULE_20] host waits half oscillator after ready; the host model waits one clock
// [RULE_21] data access writes or reads selected memory
// [RULE_22] address ranges follow line mode
// [RULE_23] narrow mode: high nibble first, busy after
// [RULE_24] first read without address set invalid
// [RULE_25] timer clears busy, busy ignores instructions
module cld_decoder
    import cld_pkg::*;
#(
    parameter int LONG_CYC  = `CLD_LONG_CYC,
    parameter int SHORT_CYC = `CLD_SHORT_CYC,
    parameter int BLINK_CYC = `CLD_BLINK_CYC
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // host transfer
    input  wire logic       cmd_data_sel,
    input  wire logic       wr_stb,
    input  wire logic       rd_stb,
    input  wire logic [7:0] data_in,
    output logic [7:0]      data_out,
    output logic            data_out_valid,
    // status and configuration
    output logic            in_progress,
    output logic [6:0]      ram_pointer,
    output logic            bus_width_sel,
    output cld_pkg::cld_fmt_t disp_format,
    output logic            panel_on,
    output logic            cursor_on,
    output logic            flash_on,
    output logic            step_up,
    output logic            auto_pan,
    output logic [6:0]      pan_offset,
    output logic            glyph_target,
    // display scan port
    input  wire logic [6:0] scan_addr,
    output logic [7:0]      scan_char,
    output logic            scan_blank,
    output logic            scan_cursor_here
);
    import cld_pkg::*;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // step a character address within the active line layout
    function automatic logic [6:0] char_step(input logic [6:0] a, input logic up,
                                             input logic two);
        logic [6:0] r;
        r = a;
        if (two) begin
            if (up) begin
                r = (a == `CLD_LINE1_END) ? `CLD_LINE2_START :
                    (a == `CLD_LINE2_END) ? `CLD_HOME_ADDR : 7'(a + 7'h1); // RULE_13
            end else begin
                r = (a == `CLD_HOME_ADDR)   ? `CLD_LINE2_END :
                    (a == `CLD_LINE2_START) ? `CLD_LINE1_END : 7'(a - 7'h1); // RULE_22
            end
        end else begin
            if (up) begin
                r = (a >= `CLD_ONE_LINE_END) ? `CLD_HOME_ADDR : 7'(a + 7'h1);
            end else begin
                r = (a == `CLD_HOME_ADDR) ? `CLD_ONE_LINE_END : 7'(a - 7'h1);
            end
        end
        return r;
    endfunction

    // linear index of a character address; one-line addresses are already linear
    function automatic logic [6:0] char_index(input logic [6:0] a, input logic two);
        return (two && a[6]) ? 7'(a - `CLD_LINE2_START + 7'd40) : a; // RULE_22
    endfunction

    // ----------------------------------------------------------------
    // transfer joining and timer
    // ----------------------------------------------------------------
    logic       byte_wr;
    logic       byte_rd;
    logic       byte_sel;
    logic [7:0] byte_data;
    logic       start_long;
    logic       start_short;
    logic       timer_last;

    cld_nibble_join u_join (
        .clk        (clk),
        .rst_n      (rst_n),
        .wide_mode  (bus_width_sel),
        .wr_stb     (wr_stb),
        .rd_stb     (rd_stb),
        .sel_in     (cmd_data_sel),
        .data_in    (data_in),
        .byte_wr    (byte_wr),
        .byte_rd    (byte_rd),
        .byte_sel   (byte_sel),
        .byte_data  (byte_data),
        .second_half()
    );

    cld_exec_timer #(
        .LONG_CYC  (LONG_CYC),
        .SHORT_CYC (SHORT_CYC)
    ) u_timer (
        .clk        (clk),
        .rst_n      (rst_n),
        .start_long (start_long),
        .start_short(start_short),
        .in_progress(in_progress),
        .last_cycle (timer_last)
    );

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    cld_op_t    op;
    wire        accept_cmd  = byte_wr & ~byte_sel & ~in_progress; // RULE_25
    wire        accept_dwr  = byte_wr & byte_sel & ~in_progress;
    wire        accept_drd  = byte_rd & byte_sel & ~in_progress;
    wire        status_rd   = byte_rd & ~byte_sel;

    assign op = !accept_cmd                   ? CLD_OP_NONE  :
                byte_data[`CLD_BIT_CHAR]      ? CLD_OP_CHAR  :
                byte_data[`CLD_BIT_GLYPH]     ? CLD_OP_GLYPH :
                byte_data[`CLD_BIT_FUNC]      ? CLD_OP_FUNC  :
                byte_data[`CLD_BIT_SHIFT]     ? CLD_OP_SHIFT :
                byte_data[`CLD_BIT_DISP]      ? CLD_OP_DISP  :
                byte_data[`CLD_BIT_ENTRY]     ? CLD_OP_ENTRY :
                byte_data[`CLD_BIT_HOME]      ? CLD_OP_HOME  :
                byte_data[`CLD_BIT_CLEAR]     ? CLD_OP_CLEAR : CLD_OP_NONE;

    // status read takes no execution time
    assign start_long  = (op == CLD_OP_CLEAR) | (op == CLD_OP_HOME); // RULE_02
    assign start_short = (accept_cmd & ~start_long) | accept_dwr | accept_drd; // RULE_03

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    cld_state_t  st_reg;
    cld_state_t  st_next;
    logic [6:0]  clr_idx_reg;
    logic [7:0]  char_mem [`CLD_CHAR_DEPTH];
    logic [7:0]  glyph_mem [`CLD_GLYPH_DEPTH];
    logic        two_line;
    logic        addr_set_reg;
    logic        blink_ph_reg;
    logic [24:0] blink_cnt_reg;

    assign two_line = (disp_format == CLD_FMT_2L_5X8);
    assign st_next  = (op == CLD_OP_CLEAR) ? CLD_ST_CLEAR :
                      (st_reg == CLD_ST_CLEAR && clr_idx_reg == 7'(`CLD_CHAR_DEPTH - 1))
                          ? CLD_ST_BUSY :
                      (st_reg != CLD_ST_IDLE && !in_progress) ? CLD_ST_IDLE :
                      (start_short || start_long) ? CLD_ST_BUSY : st_reg;

    wire        is_shift   = (op == CLD_OP_SHIFT);
    wire        shift_disp = is_shift & byte_data[3];
    wire        shift_right = byte_data[2];
    wire        mem_step   = accept_dwr | accept_drd;
    wire        pan_step   = accept_dwr & ~glyph_target & auto_pan; // RULE_06
    wire [6:0]  ptr_stepped = glyph_target ? 7'({1'b0, 6'(ram_pointer[5:0] +
                              (step_up ? 6'h01 : 6'h3f))}) // RULE_07
                            : char_step(ram_pointer, step_up, two_line); // RULE_05
    wire [6:0]  ptr_cur    = char_step(ram_pointer, shift_right, two_line); // RULE_11
    wire [6:0]  ptr_next   = (op == CLD_OP_CLEAR || op == CLD_OP_HOME) ? `CLD_HOME_ADDR : // RULE_04
                             (op == CLD_OP_CHAR)  ? byte_data[6:0] : // RULE_18
                             (op == CLD_OP_GLYPH) ? {1'b0, byte_data[5:0]} : // RULE_17
                             (is_shift && !shift_disp) ? ptr_cur :
                             mem_step ? ptr_stepped : ram_pointer; // RULE_12
    // pan left on step-up writes, right on step-down
    wire        pan_left   = (shift_disp & ~shift_right) | (pan_step & step_up);
    wire        pan_rt     = (shift_disp & shift_right) | (pan_step & ~step_up);
    wire [6:0]  pan_lim    = two_line ? 7'd39 : 7'd79;
    wire [6:0]  pan_next   = (op == CLD_OP_CLEAR || op == CLD_OP_HOME) ? 7'h00 :
                             pan_left ? ((pan_offset >= pan_lim) ? 7'h00 : 7'(pan_offset + 7'h1)) :
                             pan_rt   ? ((pan_offset == 7'h00) ? pan_lim : 7'(pan_offset - 7'h1)) :
                             pan_offset;
    wire [6:0]  wr_idx     = char_index(ram_pointer, two_line);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg      <= CLD_ST_IDLE;
            clr_idx_reg <= 7'h00;
        end else begin
            st_reg      <= st_next;
            clr_idx_reg <= (st_reg == CLD_ST_CLEAR) ? 7'(clr_idx_reg + 7'h1) : 7'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (st_reg == CLD_ST_CLEAR) begin
            char_mem[clr_idx_reg] <= `CLD_SPACE_CODE; // RULE_01
        end else if (accept_dwr && !glyph_target && wr_idx < 7'(`CLD_CHAR_DEPTH)) begin
            char_mem[wr_idx] <= byte_data; // RULE_21
        end
        if (accept_dwr && glyph_target) begin
            glyph_mem[ram_pointer[5:0]] <= byte_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ram_pointer   <= 7'h00;
            pan_offset    <= 7'h00;
            glyph_target  <= 1'b0;
            step_up       <= 1'b1;
            auto_pan      <= 1'b0;
            panel_on      <= 1'b0;
            cursor_on     <= 1'b0;
            flash_on      <= 1'b0;
            bus_width_sel <= 1'b1;
            disp_format   <= CLD_FMT_1L_5X8;
            addr_set_reg  <= 1'b0;
        end else begin
            ram_pointer <= ptr_next;
            pan_offset  <= pan_next;
            if (op == CLD_OP_CLEAR) begin
                step_up      <= 1'b1; // RULE_01
                glyph_target <= 1'b0;
            end
            if (op == CLD_OP_ENTRY) begin
                step_up  <= byte_data[1];
                auto_pan <= byte_data[0];
            end
            if (op == CLD_OP_DISP) begin
                {panel_on, cursor_on, flash_on} <= byte_data[2:0]; // RULE_08 RULE_09
            end
            if (op == CLD_OP_FUNC) begin
                bus_width_sel <= byte_data[4]; // RULE_14
                disp_format   <= byte_data[3] ? CLD_FMT_2L_5X8 : // RULE_16
                                 byte_data[2] ? CLD_FMT_1L_5X11 : CLD_FMT_1L_5X8;
            end
            if (op == CLD_OP_GLYPH || op == CLD_OP_HOME) begin
                glyph_target <= (op == CLD_OP_GLYPH);
            end
            if (op == CLD_OP_CHAR) begin
                glyph_target <= 1'b0;
            end
            if (op == CLD_OP_CHAR || op == CLD_OP_GLYPH || is_shift) begin
                addr_set_reg <= 1'b1;
            end else if (accept_dwr || accept_drd) begin
                addr_set_reg <= accept_drd; // RULE_24
            end
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    wire [7:0] ram_byte = glyph_target ? glyph_mem[ram_pointer[5:0]] :
                          (wr_idx < 7'(`CLD_CHAR_DEPTH)) ? char_mem[wr_idx] : 8'h00;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            data_out       <= 8'h00;
            data_out_valid <= 1'b0;
        end else if (status_rd) begin
            data_out       <= {in_progress, ram_pointer}; // RULE_19
            data_out_valid <= 1'b1;
        end else if (accept_drd) begin
            data_out       <= ram_byte; // RULE_21
            data_out_valid <= addr_set_reg; // RULE_24
        end
    end

    // ----------------------------------------------------------------
    // cursor flash and scan
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n || !flash_on) begin
            blink_cnt_reg <= 25'h0;
            blink_ph_reg  <= 1'b0;
        end else if (blink_cnt_reg == 25'(BLINK_CYC - 1)) begin
            blink_cnt_reg <= 25'h0;
            blink_ph_reg  <= ~blink_ph_reg; // RULE_10
        end else begin
            blink_cnt_reg <= 25'(blink_cnt_reg + 25'h1);
        end
    end

    wire [6:0] scan_idx = char_index(scan_addr, two_line);
    wire       at_cursor = ~glyph_target & (scan_addr == ram_pointer);
    // blanked panel keeps the memory, only the output is masked
    assign scan_blank       = ~panel_on; // RULE_08
    assign scan_cursor_here = panel_on & cursor_on & at_cursor; // RULE_09
    assign scan_char = (!panel_on) ? 8'h00 :
                       (flash_on && blink_ph_reg && at_cursor) ? 8'hff : // RULE_10
                       (scan_idx < 7'(`CLD_CHAR_DEPTH)) ? char_mem[scan_idx] : 8'h00;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_clear_home: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
        (op == CLD_OP_CLEAR) |=> (ram_pointer == 7'h00 && step_up && in_progress))
        else $error("clear did not home pointer");
    a_long_busy: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
        start_long |=> in_progress [*8])
        else $error("long busy too short");
    a_status_free: assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
        (status_rd && !in_progress && !byte_wr) |=> !in_progress)
        else $error("status read started busy");
    a_busy_ignore: assert property (@(posedge clk) disable iff (!rst_n) // RULE_25
        (in_progress && byte_wr && !byte_sel) |=> $stable(disp_format))
        else $error("instruction taken while busy");
    a_disp_shift_ptr: assert property (@(posedge clk) disable iff (!rst_n) // RULE_12
        shift_disp |=> $stable(ram_pointer))
        else $error("display shift moved pointer");
    a_line_wrap: assert property (@(posedge clk) disable iff (!rst_n) // RULE_13
        (is_shift && !shift_disp && shift_right && two_line && ram_pointer == 7'h27)
        |=> ram_pointer == 7'h40)
        else $error("cursor did not wrap to line two");
    a_status_data: assert property (@(posedge clk) disable iff (!rst_n) // RULE_19
        status_rd |=> data_out == {$past(in_progress), $past(ram_pointer)})
        else $error("status byte wrong");
    a_glyph_load: assert property (@(posedge clk) disable iff (!rst_n) // RULE_17
        (op == CLD_OP_GLYPH) |=> (glyph_target && ram_pointer == {1'b0, $past(byte_data[5:0])}))
        else $error("glyph address not loaded");
    c_clear: cover property (@(posedge clk) op == CLD_OP_CLEAR);
    c_data_wr: cover property (@(posedge clk) accept_dwr && auto_pan);
    c_flash: cover property (@(posedge clk) flash_on && blink_ph_reg);
endmodule

//--- logic/cld_defines.svh
`ifndef CLD_DEFINES_SVH
`define CLD_DEFINES_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLD_CLK_PERIOD_NS   8
`define CLD_OSC_KHZ         540
`define CLD_LONG_EXEC_US    760
`define CLD_SHORT_EXEC_NS   18500
`define CLD_BLINK_MS        185
`define CLD_LONG_CYC        ((`CLD_LONG_EXEC_US * 1000) / `CLD_CLK_PERIOD_NS)
`define CLD_SHORT_CYC       ((`CLD_SHORT_EXEC_NS + `CLD_CLK_PERIOD_NS - 1) / `CLD_CLK_PERIOD_NS)
`define CLD_BLINK_CYC       ((`CLD_BLINK_MS * 1000000) / `CLD_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// codes and addresses
// ----------------------------------------------------------------
`define CLD_SPACE_CODE      8'h20
`define CLD_HOME_ADDR       7'h00
`define CLD_LINE1_END       7'h27
`define CLD_LINE2_START     7'h40
`define CLD_LINE2_END       7'h67
`define CLD_ONE_LINE_END    7'h4f
`define CLD_CHAR_DEPTH      80
`define CLD_GLYPH_DEPTH     64

// ----------------------------------------------------------------
// instruction bit positions
// ----------------------------------------------------------------
`define CLD_BIT_CLEAR       0
`define CLD_BIT_HOME        1
`define CLD_BIT_ENTRY       2
`define CLD_BIT_DISP        3
`define CLD_BIT_SHIFT       4
`define CLD_BIT_FUNC        5
`define CLD_BIT_GLYPH       6
`define CLD_BIT_CHAR        7

`endif

//--- logic/cld_exec_timer.sv
`timescale 1ns/100ps
`include "cld_defines.svh"
// counts the execution time of one instruction and holds in_progress
module cld_exec_timer #(
    parameter int LONG_CYC  = `CLD_LONG_CYC,
    parameter int SHORT_CYC = `CLD_SHORT_CYC
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // control
    input  wire logic start_long,
    input  wire logic start_short,
    // status
    output logic      in_progress,
    output logic      last_cycle
);
    logic [16:0] cnt_reg;
    logic [16:0] cnt_next;

    assign cnt_next = start_long  ? 17'(LONG_CYC - 1) :
                      start_short ? 17'(SHORT_CYC - 1) :
                      (cnt_reg != 17'h0) ? cnt_reg - 17'h1 : 17'h0;
    assign in_progress = (cnt_reg != 17'h0);
    assign last_cycle  = (cnt_reg == 17'h1);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_reg <= 17'h0;
        end else begin
            cnt_reg <= cnt_next; // RULE_25
        end
    end
endmodule

//--- logic/cld_nibble_join.sv
`timescale 1ns/100ps
// joins two 4-bit transfers into one byte when narrow mode is set
module cld_nibble_join
    import cld_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // host side
    input  wire logic       wide_mode,
    input  wire logic       wr_stb,
    input  wire logic       rd_stb,
    input  wire logic       sel_in,
    input  wire logic [7:0] data_in,
    // joined side
    output logic            byte_wr,
    output logic            byte_rd,
    output logic            byte_sel,
    output logic [7:0]      byte_data,
    output logic            second_half
);
    logic       half_reg;
    logic       half_next;
    logic [3:0] hi_reg;
    logic [3:0] hi_next;
    wire        any_stb;
    wire        complete;

    assign any_stb     = wr_stb | rd_stb;
    // upper nibble first on data_in[7:4]; strobe only after the second half
    assign complete    = any_stb & (wide_mode | half_reg); // RULE_23
    assign half_next   = wide_mode ? 1'b0 : (any_stb ? ~half_reg : half_reg);
    assign hi_next     = (any_stb & ~half_reg) ? data_in[7:4] : hi_reg;
    assign byte_wr     = complete & wr_stb;
    assign byte_rd     = complete & rd_stb;
    assign byte_sel    = sel_in;
    assign byte_data   = wide_mode ? data_in : {hi_reg, data_in[7:4]};
    assign second_half = half_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            half_reg <= 1'b0;
            hi_reg   <= 4'h0;
        end else begin
            half_reg <= half_next;
            hi_reg   <= hi_next;
        end
    end

    a_nibble_pair: assert property (@(posedge clk) disable iff (!rst_n) // RULE_23
        (!wide_mode && wr_stb && !half_reg) |-> !byte_wr)
        else $error("narrow write completed on first half");
endmodule

//--- logic/cld_pkg.sv
package cld_pkg;
    typedef enum logic [1:0] {
        CLD_ST_IDLE,
        CLD_ST_CLEAR,
        CLD_ST_BUSY
    } cld_state_t;

    typedef enum logic [3:0] {
        CLD_OP_NONE,
        CLD_OP_CLEAR,
        CLD_OP_HOME,
        CLD_OP_ENTRY,
        CLD_OP_DISP,
        CLD_OP_SHIFT,
        CLD_OP_FUNC,
        CLD_OP_GLYPH,
        CLD_OP_CHAR
    } cld_op_t;

    typedef enum logic [1:0] {
        CLD_FMT_1L_5X8,
        CLD_FMT_1L_5X11,
        CLD_FMT_2L_5X8
    } cld_fmt_t;
endpackage
